// file: hw/sbc_core.sv
// Storage boost charger control: start, regulation, top-off and code decoding
`timescale 1ns/1ps
// Functional notes
// - Start only after ramp done and enable high
// - Leave ramp 10ms after output nears input
// - At target stop charging, go standby, compare
// - Standby restarts below 95 percent of target
// - Supplement entry kills top-off immediately
// - Peak code selects 250/500/950/1500 mA
// - Switch on to peak, off to zero
// - Five-bit storage code gives 5V to 28V
// - Codes 11000 to 11111 all mean 28V
// - Storage code and threshold defaults come from factory option; peak code resets to 00
// - Power-good only above selected threshold
// - Shared four-bit threshold 95.0 to 98.0 percent; code applies it to power-good only, standby restart stays fixed at 95 percent
// - Supplement when input leaves its window
// - Step-down runs until storage reaches 3.0V
module sbc_core #(
    // Inrush hold in clock cycles; a bench may shorten it to keep runs small
    parameter int RAMP_CYC = sbc_pkg::RAMP_HOLD_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic converter_enable_pin,
    input wire logic [15:0] vout_mv,
    input wire logic [15:0] vin_mv,
    input wire logic [15:0] storage_rail_mv,
    input wire logic input_in_window,
    input wire logic peak_reached,
    input wire logic inductor_zero,
    input wire logic cfg_load,
    input wire logic [1:0] boost_peak_current_code,
    input wire logic [4:0] storage_voltage_code,
    input wire logic [3:0] capacitor_drop_threshold_code,
    input wire logic [4:0] factory_option_vset,
    input wire logic [3:0] factory_option_thr,
    output logic ramp_done,
    output logic boost_switch_on,
    output logic [1:0] boost_state,
    output logic supplement_mode,
    output logic buck_on,
    output logic storage_pg,
    output logic [11:0] peak_ma,
    output logic [15:0] target_mv,
    output logic [9:0] pg_permille
);
    localparam int RW = $clog2(RAMP_CYC + 1);

    // Peak current decode
    function automatic logic [11:0] peak_decode(input logic [1:0] c);
        case (c)
            2'b00: peak_decode = sbc_pkg::PEAK_MA_0;
            2'b01: peak_decode = sbc_pkg::PEAK_MA_1;
            2'b10: peak_decode = sbc_pkg::PEAK_MA_2;
            default: peak_decode = sbc_pkg::PEAK_MA_3;
        endcase
    endfunction

    // Storage voltage decode, upper codes saturate at the maximum
    function automatic logic [15:0] vset_decode(input logic [4:0] c);
        logic [15:0] k;
        k = {12'h000, c[3:0]};
        if (c[4] && c[3]) begin
            vset_decode = sbc_pkg::VSET_MAX_MV;
        end else if (c[4]) begin
            vset_decode = 16'(sbc_pkg::VSET_HIGH_BASE_MV + k * sbc_pkg::VSET_STEP_MV);
        end else if (c[3:0] == 4'h0) begin
            vset_decode = sbc_pkg::VSET_MIN_MV;
        end else if (c[3:0] == 4'h1) begin
            vset_decode = sbc_pkg::VSET_SECOND_MV;
        end else begin
            vset_decode = 16'(sbc_pkg::VSET_LOW_BASE_MV + (k - 16'h0002) * sbc_pkg::VSET_STEP_MV);
        end
    endfunction

    // Percent-of-target compare: v*1000 >= t*pm
    function automatic logic at_or_above(input logic [15:0] v, input logic [15:0] t,
                                         input logic [9:0] pm);
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs = 32'(v) * 32'd1000;
        rhs = 32'(t) * 32'(pm);
        at_or_above = (lhs >= rhs);
    endfunction

    // Configuration registers
    logic [4:0] vset_q, vset_d;
    logic [3:0] thr_q, thr_d;
    logic [1:0] clim_q, clim_d;
    logic cfg_init_q, cfg_init_d;

    // Storage code and threshold defaults taken from the factory option after reset release, then host codes
    always_comb begin
        vset_d = vset_q;
        thr_d = thr_q;
        clim_d = clim_q;
        cfg_init_d = 1'b1;
        if (!cfg_init_q) begin
            vset_d = factory_option_vset;
            thr_d = factory_option_thr;
        end else if (cfg_load) begin
            vset_d = storage_voltage_code;
            thr_d = capacitor_drop_threshold_code;
            clim_d = boost_peak_current_code;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vset_q <= 5'h00;
            thr_q <= 4'h0;
            clim_q <= 2'h0;
            cfg_init_q <= 1'b0;
        end else begin
            vset_q <= vset_d;
            thr_q <= thr_d;
            clim_q <= clim_d;
            cfg_init_q <= cfg_init_d;
        end
    end

    // Decoded settings
    logic [15:0] tgt;
    logic [9:0] pgp;
    logic near_in;
    logic [16:0] vin_hi;
    assign tgt = vset_decode(vset_q);
    assign pgp = 10'(sbc_pkg::PG_BASE_PERMILLE + {6'h00, thr_q} * sbc_pkg::PG_STEP_PERMILLE);
    assign vin_hi = 17'(vin_mv) + 17'(sbc_pkg::NEAR_MV);
    assign near_in = (17'(vout_mv) + 17'(sbc_pkg::NEAR_MV) >= 17'(vin_mv))
                   && (17'(vout_mv) <= vin_hi);

    // Inrush ramp timer
    logic [RW-1:0] ramp_cnt_q, ramp_cnt_d;
    logic ramp_done_q, ramp_done_d;
    always_comb begin
        ramp_cnt_d = ramp_cnt_q;
        ramp_done_d = ramp_done_q;
        if (!ramp_done_q && near_in) begin
            if (ramp_cnt_q == RW'(RAMP_CYC - 1)) begin
                ramp_done_d = 1'b1;
            end else begin
                ramp_cnt_d = ramp_cnt_q + RW'(1);
            end
        end
    end

    // Supplement and step-down control
    logic supp_q, supp_d;
    logic buck_q, buck_d;
    always_comb begin
        supp_d = supp_q;
        buck_d = buck_q;
        if (!supp_q && ramp_done_q && !input_in_window) begin
            supp_d = 1'b1;
            buck_d = converter_enable_pin;
        end else if (supp_q && buck_q && storage_rail_mv <= sbc_pkg::STR_EMPTY_MV) begin
            buck_d = 1'b0;
        end else if (supp_q && input_in_window && !buck_q) begin
            supp_d = 1'b0;
        end
        if (!converter_enable_pin) begin
            buck_d = 1'b0;
        end
    end

    // Boost state machine and switch
    sbc_pkg::sbc_boost_t st_q, st_d;
    logic sw_q, sw_d;
    logic topping_q, topping_d;
    always_comb begin
        st_d = st_q;
        sw_d = sw_q;
        topping_d = topping_q;
        case (st_q)
            sbc_pkg::SBC_OFF: begin
                sw_d = 1'b0;
                if (ramp_done_q && converter_enable_pin && !supp_q) begin
                    st_d = sbc_pkg::SBC_CHARGE;
                    sw_d = 1'b1;
                    topping_d = 1'b0;
                end
            end
            sbc_pkg::SBC_CHARGE: begin
                if (storage_rail_mv >= tgt) begin
                    st_d = sbc_pkg::SBC_STANDBY;
                    sw_d = 1'b0;
                end else if (sw_q && peak_reached) begin
                    sw_d = 1'b0;
                end else if (!sw_q && inductor_zero) begin
                    sw_d = 1'b1;
                end
            end
            sbc_pkg::SBC_STANDBY: begin
                sw_d = 1'b0;
                if (!at_or_above(storage_rail_mv, tgt, sbc_pkg::TOPOFF_PERMILLE)) begin
                    st_d = sbc_pkg::SBC_CHARGE;
                    sw_d = 1'b1;
                    topping_d = 1'b1;
                end
            end
            default: begin
                st_d = sbc_pkg::SBC_OFF;
                sw_d = 1'b0;
            end
        endcase
        if (supp_d && topping_q && st_q == sbc_pkg::SBC_CHARGE) begin
            st_d = sbc_pkg::SBC_OFF;
            sw_d = 1'b0;
            topping_d = 1'b0;
        end
        if (!converter_enable_pin || supp_d) begin
            st_d = sbc_pkg::SBC_OFF;
            sw_d = 1'b0;
        end
    end

    // Output registers
    logic pg_d;
    // Strictly above the threshold; sitting exactly on it reads as not good
    assign pg_d = (32'(storage_rail_mv) * 32'd1000) > (32'(tgt) * 32'(pgp));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ramp_cnt_q <= '0;
            ramp_done_q <= 1'b0;
            supp_q <= 1'b0;
            buck_q <= 1'b0;
            st_q <= sbc_pkg::SBC_OFF;
            sw_q <= 1'b0;
            topping_q <= 1'b0;
            storage_pg <= 1'b0;
            peak_ma <= 12'h000;
            target_mv <= 16'h0000;
            pg_permille <= 10'h000;
        end else begin
            ramp_cnt_q <= ramp_cnt_d;
            ramp_done_q <= ramp_done_d;
            supp_q <= supp_d;
            buck_q <= buck_d;
            st_q <= st_d;
            sw_q <= sw_d;
            topping_q <= topping_d;
            storage_pg <= pg_d;
            peak_ma <= peak_decode(clim_q);
            target_mv <= tgt;
            pg_permille <= pgp;
        end
    end

    assign ramp_done = ramp_done_q;
    assign boost_switch_on = sw_q;
    assign boost_state = st_q;
    assign supplement_mode = supp_q;
    assign buck_on = buck_q;

    // Checks
    property p_start;
        @(posedge clk) disable iff (reset)
        (st_q == sbc_pkg::SBC_OFF && $past(st_q) == sbc_pkg::SBC_OFF) ##1
        (st_q == sbc_pkg::SBC_CHARGE) |-> $past(ramp_done_q && converter_enable_pin);
    endproperty
    a_start: assert property (p_start) else $error("boost started without qualification");
    property p_ramp;
        @(posedge clk) disable iff (reset)
        $rose(ramp_done_q) |-> $past(near_in);
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp left while output far");
    property p_standby;
        @(posedge clk) disable iff (reset)
        (st_q == sbc_pkg::SBC_CHARGE && storage_rail_mv >= tgt) |=> (st_q != sbc_pkg::SBC_CHARGE);
    endproperty
    a_standby: assert property (p_standby) else $error("charging past target");
    property p_topoff;
        @(posedge clk) disable iff (reset)
        (st_q == sbc_pkg::SBC_STANDBY && converter_enable_pin && !supp_d
         && !at_or_above(storage_rail_mv, tgt, sbc_pkg::TOPOFF_PERMILLE))
        |=> (st_q == sbc_pkg::SBC_CHARGE && sw_q);
    endproperty
    a_topoff: assert property (p_topoff) else $error("top-off not restarted");
    property p_supp_off;
        @(posedge clk) disable iff (reset)
        $rose(supp_q) |-> (st_q == sbc_pkg::SBC_OFF && !sw_q);
    endproperty
    a_supp_off: assert property (p_supp_off) else $error("boost on in supplement");
    property p_peak;
        @(posedge clk) disable iff (reset)
        (clim_q == 2'b10) |=> (peak_ma == sbc_pkg::PEAK_MA_2);
    endproperty
    a_peak: assert property (p_peak) else $error("peak decode wrong");
    property p_switch;
        @(posedge clk) disable iff (reset)
        (st_q == sbc_pkg::SBC_CHARGE && sw_q && !peak_reached) |=> (sw_q || st_q != sbc_pkg::SBC_CHARGE);
    endproperty
    a_switch: assert property (p_switch) else $error("switch dropped before peak");
    property p_vset;
        @(posedge clk) disable iff (reset)
        (vset_q[4:3] == 2'b11) |=> (target_mv == sbc_pkg::VSET_MAX_MV);
    endproperty
    a_vset: assert property (p_vset) else $error("saturated code not max");
    property p_enable;
        @(posedge clk) disable iff (reset)
        !converter_enable_pin |=> (st_q == sbc_pkg::SBC_OFF && !sw_q);
    endproperty
    a_enable: assert property (p_enable) else $error("boost alive with enable low");
    c_standby: cover property (@(posedge clk) disable iff (reset)
        st_q == sbc_pkg::SBC_STANDBY ##1 st_q == sbc_pkg::SBC_CHARGE);
    c_supp: cover property (@(posedge clk) disable iff (reset) $rose(supp_q) && topping_q);
    c_buck_end: cover property (@(posedge clk) disable iff (reset) $fell(buck_q) && supp_q);
endmodule

// file: inc/sbc_pkg.sv
// Constants and types for the storage boost control block
package sbc_pkg;
    // Clock rate
    localparam int CLK_MHZ = 100;
    // Inrush ramp hold after output comes near input
    localparam int RAMP_HOLD_MS = 10;
    localparam int RAMP_HOLD_CYC = RAMP_HOLD_MS * 1000 * CLK_MHZ;
    // Voltages carried in millivolts, 16 bits
    localparam logic [15:0] NEAR_MV = 16'h00C8;
    localparam logic [15:0] STR_EMPTY_MV = 16'h0BB8;
    // Top-off re-arm level in tenths of a percent
    localparam logic [9:0] TOPOFF_PERMILLE = 10'h3B6;
    // Power-good threshold base and step in tenths of a percent
    localparam logic [9:0] PG_BASE_PERMILLE = 10'h3B6;
    localparam logic [9:0] PG_STEP_PERMILLE = 10'h002;
    // Peak current settings in mA
    localparam logic [11:0] PEAK_MA_0 = 12'h0FA;
    localparam logic [11:0] PEAK_MA_1 = 12'h1F4;
    localparam logic [11:0] PEAK_MA_2 = 12'h3B6;
    localparam logic [11:0] PEAK_MA_3 = 12'h5DC;
    // Storage target table anchors in mV
    localparam logic [15:0] VSET_MIN_MV = 16'h1388;
    localparam logic [15:0] VSET_SECOND_MV = 16'h15E0;
    localparam logic [15:0] VSET_STEP_MV = 16'h03E8;
    localparam logic [15:0] VSET_LOW_BASE_MV = 16'h1B58;
    localparam logic [15:0] VSET_HIGH_BASE_MV = 16'h5208;
    localparam logic [15:0] VSET_MAX_MV = 16'h6D60;
    // Boost states
    typedef enum logic [1:0] {
        SBC_OFF = 2'b00,
        SBC_CHARGE = 2'b01,
        SBC_STANDBY = 2'b10
    } sbc_boost_t;
endpackage

// file: test/sbc_core_tb.sv
// Self-checking bench for the storage boost control block
`timescale 1ns/1ps
module sbc_core_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic converter_enable_pin = 1'b1;
    logic [15:0] vout_mv = 16'h0000;
    logic [15:0] vin_mv = 16'h0CE4;
    logic [15:0] storage_rail_mv = 16'h0000;
    logic input_in_window = 1'b1;
    logic peak_reached = 1'b0;
    logic inductor_zero = 1'b0;
    logic cfg_load = 1'b0;
    logic [1:0] boost_peak_current_code = 2'h0;
    logic [4:0] storage_voltage_code = 5'h00;
    logic [3:0] capacitor_drop_threshold_code = 4'h0;
    logic [4:0] factory_option_vset = 5'h17;
    logic [3:0] factory_option_thr = 4'h3;
    logic ramp_done, boost_switch_on, supplement_mode, buck_on, storage_pg;
    logic [1:0] boost_state;
    logic [11:0] peak_ma;
    logic [15:0] target_mv;
    logic [9:0] pg_permille;
    logic [15:0] pk [4] = '{16'h00FA, 16'h01F4, 16'h03B6, 16'h05DC};
    int miscompares = 0;
    int compares = 0;
    // Shortened inrush hold so the ramp test stays small
    localparam int RAMP_CYC = 1000;

    sbc_core #(
        .RAMP_CYC(RAMP_CYC)
    ) sbc_core_inst (
        .clk(clk),
        .reset(reset),
        .converter_enable_pin(converter_enable_pin),
        .vout_mv(vout_mv),
        .vin_mv(vin_mv),
        .storage_rail_mv(storage_rail_mv),
        .input_in_window(input_in_window),
        .peak_reached(peak_reached),
        .inductor_zero(inductor_zero),
        .cfg_load(cfg_load),
        .boost_peak_current_code(boost_peak_current_code),
        .storage_voltage_code(storage_voltage_code),
        .capacitor_drop_threshold_code(capacitor_drop_threshold_code),
        .factory_option_vset(factory_option_vset),
        .factory_option_thr(factory_option_thr),
        .ramp_done(ramp_done),
        .boost_switch_on(boost_switch_on),
        .boost_state(boost_state),
        .supplement_mode(supplement_mode),
        .buck_on(buck_on),
        .storage_pg(storage_pg),
        .peak_ma(peak_ma),
        .target_mv(target_mv),
        .pg_permille(pg_permille)
    );

    // 100 MHz clock
    always #5 clk = ~clk;

    // Waits n edges and lets their updates land
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Compares one observed value with its expectation
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Loads all three codes with a one-cycle strobe
    task automatic load(input logic [1:0] p, input logic [4:0] v, input logic [3:0] t);
        @(posedge clk);
        boost_peak_current_code <= p;
        storage_voltage_code <= v;
        capacitor_drop_threshold_code <= t;
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
        step(3);
    endtask

    // Moves the storage rail level
    task automatic rail(input logic [15:0] v);
        @(posedge clk);
        storage_rail_mv <= v;
        step(3);
    endtask

    // Storage target expected for a five-bit code
    function automatic logic [15:0] vset_mv(input logic [4:0] c);
        if (c[4]) return c[3] ? 16'h6D60 : 16'h5208 + 16'(c[2:0]) * 16'h03E8;
        if (c == 5'h00) return 16'h1388;
        if (c == 5'h01) return 16'h15E0;
        return 16'h1B58 + 16'(c - 5'h02) * 16'h03E8;
    endfunction

    // Prints the counts and the verdict, then stops
    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        #((RAMP_CYC + 5000) * 10);
        miscompares++;
        $display("BAD watchdog expected finish seen hang");
        give_verdict();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        step(3);
        chk("target", 16'h6D60, target_mv);
        chk("pg_permille", 16'h03BC, 16'(pg_permille));
        chk("peak", 16'h00FA, 16'(peak_ma));
        $display("test defaults done");
        for (int i = 0; i < 32; i++) begin
            load(2'(i), 5'(i), 4'(i));
            chk("peak", pk[i % 4], 16'(peak_ma));
            chk("target", vset_mv(5'(i)), target_mv);
            chk("pg_permille", 16'h03B6 + 16'(i % 16) * 16'h0002, 16'(pg_permille));
        end
        $display("test decode done");
        load(2'h0, 5'h00, 4'h0);
        @(posedge clk);
        vout_mv <= 16'h0C1C;
        step(RAMP_CYC - 10);
        chk("ramp_done early", 16'h0000, 16'(ramp_done));
        chk("state before ramp", 16'h0000, 16'(boost_state));
        step(20);
        chk("ramp_done", 16'h0001, 16'(ramp_done));
        chk("state start", 16'h0001, 16'(boost_state));
        chk("switch start", 16'h0001, 16'(boost_switch_on));
        $display("test ramp done");
        @(posedge clk);
        peak_reached <= 1'b1;
        step(3);
        chk("switch at peak", 16'h0000, 16'(boost_switch_on));
        @(posedge clk);
        peak_reached <= 1'b0;
        step(3);
        chk("switch waits zero", 16'h0000, 16'(boost_switch_on));
        @(posedge clk);
        inductor_zero <= 1'b1;
        step(3);
        chk("switch at zero", 16'h0001, 16'(boost_switch_on));
        @(posedge clk);
        inductor_zero <= 1'b0;
        $display("test switching done");
        rail(16'h1387);
        chk("state below target", 16'h0001, 16'(boost_state));
        chk("pg above", 16'h0001, 16'(storage_pg));
        rail(16'h1388);
        chk("state standby", 16'h0002, 16'(boost_state));
        rail(16'h128E);
        chk("state at 95", 16'h0002, 16'(boost_state));
        chk("pg at threshold", 16'h0000, 16'(storage_pg));
        rail(16'h128D);
        chk("state topping", 16'h0001, 16'(boost_state));
        $display("test regulation done");
        @(posedge clk);
        input_in_window <= 1'b0;
        step(3);
        chk("supplement", 16'h0001, 16'(supplement_mode));
        chk("state supplement", 16'h0000, 16'(boost_state));
        chk("buck on", 16'h0001, 16'(buck_on));
        rail(16'h0BB9);
        chk("buck above empty", 16'h0001, 16'(buck_on));
        rail(16'h0BB8);
        chk("buck empty", 16'h0000, 16'(buck_on));
        @(posedge clk);
        input_in_window <= 1'b1;
        step(3);
        chk("supplement cleared", 16'h0000, 16'(supplement_mode));
        chk("state recharge", 16'h0001, 16'(boost_state));
        $display("test supplement done");
        @(posedge clk);
        converter_enable_pin <= 1'b0;
        step(5);
        chk("state enable low", 16'h0000, 16'(boost_state));
        @(posedge clk);
        converter_enable_pin <= 1'b1;
        step(3);
        chk("state enable back", 16'h0001, 16'(boost_state));
        @(posedge clk);
        reset <= 1'b1;
        step(2);
        chk("state reset", 16'h0000, 16'(boost_state));
        chk("switch reset", 16'h0000, 16'(boost_switch_on));
        @(posedge clk);
        reset <= 1'b0;
        step(3);
        chk("ramp after reset", 16'h0000, 16'(ramp_done));
        $display("test enable and reset done");
        give_verdict();
    end
endmodule
